// file: umc_map_codec.sv
// Upstream allocation map body builder with APB register access and byte stream out
//
// Functional notes
// - Send upstream channel identifier in body
// - Send UCD change count from register
// - Element count equals stored element total
// - Send allocation start time in mini-slots
// - Send latest processed acknowledgement time
// - Ranging backoff exponents 0-15, upper zero
// - Data backoff exponents 0-15, upper zero
// - Effective times keep low 26-M bits
// - Element word: SID, IUC, offset
// - IUC 1 request region, any SID
// - IUC 2 request or data, multicast
// - IUC 3 initial ranging, broadcast SID
// - IUC 4 periodic ranging, unicast SID
// - Periodic ranging SID temporary or primary
// - IUC 5/6 grants; zero length pending
// - IUC 7 null element needs SID zero
// - Data ack offset carries map length
// - IUC 15 offset counts extra words
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module umc_map_codec
    import umc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Message body byte stream
    output logic             map_valid,
    input  wire logic        map_ready,
    output logic      [7:0]  map_data,
    output logic             map_last,
    // Status
    output logic             busy
);

    umc_st_t r;        // Registered state
    umc_st_t n;        // Next state

    logic        setup;      // APB setup cycle
    logic        wr_go;      // Accepted write in access phase
    logic        err_set;    // Element or send refused this cycle
    logic        err_clr;    // Software clears the error flag
    logic [31:0] w;          // Element word as it will be stored
    logic [13:0] w_sid;      // SID of incoming word
    logic [3:0]  w_iuc;      // IUC of incoming word
    logic        w_bad;      // Element breaks its SID class
    logic        full;       // Element store has no room
    logic [7:0]  total;      // Body length in bytes
    logic [31:0] eff_mask;   // Mask of effective time bits

    // Byte of the message body at position i, network order
    function automatic logic [7:0] map_byte(input umc_st_t s, input logic [7:0] i);
        logic [7:0]       b;
        logic [7:0]       rel;
        logic [CNT_W-1:0] wi;
        b   = 8'h00;
        rel = i - HDR_BYTES;
        wi  = rel[CNT_W+1:2];
        unique case (i)
            P_CHAN:  b = s.chan_id;
            P_UCD:   b = s.ucd_cnt;
            P_NELEM: b = s.nelem;
            // Alignment byte is always zero
            P_RSVD:  b = 8'h00;
            P_ALLOC:          b = s.alloc[31:24];
            P_ALLOC + 8'h01:  b = s.alloc[23:16];
            P_ALLOC + 8'h02:  b = s.alloc[15:8];
            P_ALLOC + 8'h03:  b = s.alloc[7:0];
            P_ACK:            b = s.ack[31:24];
            P_ACK + 8'h01:    b = s.ack[23:16];
            P_ACK + 8'h02:    b = s.ack[15:8];
            P_ACK + 8'h03:    b = s.ack[7:0];
            P_RBS:   b = {4'h0, s.rbs};
            P_RBE:   b = {4'h0, s.rbe};
            P_DBS:   b = {4'h0, s.dbs};
            P_DBE:   b = {4'h0, s.dbe};
            default: begin
                // element words, most significant byte first
                unique case (rel[1:0])
                    2'b00:   b = s.ie[wi][31:24];
                    2'b01:   b = s.ie[wi][23:16];
                    2'b10:   b = s.ie[wi][15:8];
                    default: b = s.ie[wi][7:0];
                endcase
            end
        endcase
        return b;
    endfunction : map_byte

    // Always ready; read data was prepared in the setup cycle
    assign pready    = 1'b1;
    assign prdata    = r.prdata;
    assign pslverr   = r.pslverr;
    assign map_valid = r.out_valid;
    assign map_data  = r.out_data;
    assign map_last  = r.out_last;
    assign busy      = (r.st == ST_SEND);

    // Next state of registers, store and sender
    always_comb begin
        n        = r;
        setup    = psel & ~penable;
        wr_go    = psel & penable & pwrite & ~r.pslverr;
        err_set  = 1'b0;
        err_clr  = 1'b0;
        full     = (r.nwords == CNT_W'(IE_DEPTH));
        total    = HDR_BYTES + {r.nwords, 2'b00};
        // effective bits are the low 26-M
        eff_mask = TIME_MASK >> r.mbits;
        w        = pwdata;
        w_sid    = pwdata[SID_LSB +: SID_W];
        w_iuc    = pwdata[IUC_LSB +: IUC_W];
        w_bad    = 1'b0;

        // Read mux and error decode, captured in the setup cycle
        if (setup) begin
            n.pslverr = 1'b0;
            n.prdata  = 32'h0000_0000;
            unique case (paddr)
                A_CTRL:    n.prdata = 32'h0000_0000;
                A_STATUS:  begin
                    n.prdata[STAT_BUSY] = busy;
                    n.prdata[STAT_ERR]  = r.err;
                    n.prdata[STAT_FULL] = full;
                    n.prdata[STAT_EXT]  = (r.ext_left != 14'h0000);
                end
                A_CHAN:    n.prdata = {24'h00_0000, r.chan_id};
                A_UCD:     n.prdata = {24'h00_0000, r.ucd_cnt};
                A_ALLOC:   n.prdata = r.alloc;
                A_ACK:     n.prdata = r.ack;
                A_BACKOFF: begin
                    n.prdata[BO_RS +: 4] = r.rbs;
                    n.prdata[BO_RE +: 4] = r.rbe;
                    n.prdata[BO_DS +: 4] = r.dbs;
                    n.prdata[BO_DE +: 4] = r.dbe;
                end
                A_MBITS:   n.prdata = {27'h000_0000, r.mbits};
                A_MAPLEN:  n.prdata = {18'h0_0000, r.map_len};
                A_IE_PUSH: n.prdata = {16'h0000, r.nelem, 2'b00, r.nwords};
                A_ALLOC_EFF: n.prdata = r.alloc & eff_mask;
                A_ACK_EFF:   n.prdata = r.ack & eff_mask;
                // Unmapped offsets answer with an error
                default:   n.pslverr = 1'b1;
            endcase
            // The store is frozen while a body is being sent
            if (pwrite && busy && (paddr == A_IE_PUSH || paddr == A_CTRL)) begin
                n.pslverr = 1'b1;
            end
            // No room for another word
            if (pwrite && full && paddr == A_IE_PUSH) begin
                n.pslverr = 1'b1;
            end
        end

        // Register writes in the access phase
        if (wr_go) begin
            unique case (paddr)
                A_CTRL: begin
                    if (pwdata[CTRL_CLEAR]) begin
                        n.nwords   = '0;
                        n.nelem    = 8'h00;
                        n.ext_left = 14'h0000;
                    end else if (pwdata[CTRL_SEND]) begin
                        // An open expansion element cannot be sent
                        if (r.ext_left != 14'h0000) begin
                            err_set = 1'b1;
                        end else begin
                            n.st        = ST_SEND;
                            n.idx       = P_CHAN;
                            n.out_valid = 1'b1;
                            n.out_data  = map_byte(r, P_CHAN);
                            n.out_last  = 1'b0;
                        end
                    end
                end
                A_STATUS:  err_clr = pwdata[STAT_ERR];
                A_CHAN:    n.chan_id = pwdata[7:0];
                A_UCD:     n.ucd_cnt = pwdata[7:0];
                A_ALLOC:   n.alloc = pwdata;
                A_ACK:     n.ack = pwdata;
                A_BACKOFF: begin
                    // ranging exponents held in four bits
                    n.rbs = pwdata[BO_RS +: 4];
                    n.rbe = pwdata[BO_RE +: 4];
                    // data exponents held in four bits
                    n.dbs = pwdata[BO_DS +: 4];
                    n.dbe = pwdata[BO_DE +: 4];
                end
                A_MBITS:   n.mbits = pwdata[4:0];
                A_MAPLEN:  n.map_len = pwdata[OFS_W-1:0];
                A_IE_PUSH: begin
                    if (r.ext_left != 14'h0000) begin
                        // raw words of an expansion element
                        n.ie[r.nwords] = pwdata;
                        n.nwords       = r.nwords + CNT_W'(1);
                        n.ext_left     = r.ext_left - 14'h0001;
                    end else begin
                        // initial ranging needs the broadcast SID
                        if (w_iuc == IUC_INIT && w_sid != SID_BCAST) begin
                            w_bad = 1'b1;
                        end
                        // periodic ranging needs a unicast SID
                        // zero and broadcast are never modem SIDs
                        if (w_iuc == IUC_STAT && (w_sid == SID_ZERO || w_sid == SID_BCAST)) begin
                            w_bad = 1'b1;
                        end
                        // null element only with SID zero
                        if (w_iuc == IUC_NULL && w_sid != SID_ZERO) begin
                            w_bad = 1'b1;
                        end
                        // data ack offset forced to map length
                        if (w_iuc == IUC_DACK) begin
                            w[OFS_W-1:0] = r.map_len;
                        end
                        if (w_bad) begin
                            err_set = 1'b1;
                        end else begin
                            n.ie[r.nwords] = w;
                            n.nwords       = r.nwords + CNT_W'(1);
                            // one count per element, not per word
                            n.nelem        = r.nelem + 8'h01;
                            // offset field counts words to follow
                            if (w_iuc == IUC_EXP) begin
                                n.ext_left = w[OFS_W-1:0];
                            end
                        end
                    end
                end
                default: begin
                    // Read-only or unmapped: nothing stored
                end
            endcase
        end

        // Error flag: a new error wins over a clear
        n.err = (r.err & ~err_clr) | err_set;

        // Byte stream sender, advanced on each accepted byte
        unique case (r.st)
            ST_IDLE: begin
                // Waits for a send command
            end
            ST_SEND: begin
                if (r.out_valid && map_ready) begin
                    if (r.out_last) begin
                        n.st        = ST_IDLE;
                        n.out_valid = 1'b0;
                        n.out_last  = 1'b0;
                    end else begin
                        n.idx      = r.idx + 8'h01;
                        n.out_data = map_byte(r, r.idx + 8'h01);
                        n.out_last = ((r.idx + 8'h01) == (total - 8'h01));
                    end
                end
            end
        endcase
    end

    // Single state register; the whole struct clears on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : umc_map_codec

// file: umc_pkg.sv
// Constants, register map and state types for the upstream allocation map codec
package umc_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_STATUS    = 8'h04;
    localparam logic [7:0] A_CHAN      = 8'h08;
    localparam logic [7:0] A_UCD       = 8'h0C;
    localparam logic [7:0] A_ALLOC     = 8'h10;
    localparam logic [7:0] A_ACK       = 8'h14;
    localparam logic [7:0] A_BACKOFF   = 8'h18;
    localparam logic [7:0] A_MBITS     = 8'h1C;
    localparam logic [7:0] A_MAPLEN    = 8'h20;
    localparam logic [7:0] A_IE_PUSH   = 8'h24;
    localparam logic [7:0] A_ALLOC_EFF = 8'h28;
    localparam logic [7:0] A_ACK_EFF   = 8'h2C;

    // Control and status bit positions
    localparam int CTRL_SEND  = 0;
    localparam int CTRL_CLEAR = 1;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_ERR   = 1;
    localparam int STAT_FULL  = 2;
    localparam int STAT_EXT   = 3;

    // Backoff nibble positions inside the backoff register
    localparam int BO_RS = 0;
    localparam int BO_RE = 8;
    localparam int BO_DS = 16;
    localparam int BO_DE = 24;

    // Element store
    localparam int IE_DEPTH = 32;
    localparam int CNT_W    = 6;

    // Element word layout
    localparam int SID_LSB = 18;
    localparam int IUC_LSB = 14;
    localparam int SID_W   = 14;
    localparam int IUC_W   = 4;
    localparam int OFS_W   = 14;

    // Interval usage codes
    localparam logic [3:0] IUC_REQ   = 4'h1;
    localparam logic [3:0] IUC_REQD  = 4'h2;
    localparam logic [3:0] IUC_INIT  = 4'h3;
    localparam logic [3:0] IUC_STAT  = 4'h4;
    localparam logic [3:0] IUC_SHORT = 4'h5;
    localparam logic [3:0] IUC_LONG  = 4'h6;
    localparam logic [3:0] IUC_NULL  = 4'h7;
    localparam logic [3:0] IUC_DACK  = 4'h8;
    localparam logic [3:0] IUC_EXP   = 4'hF;

    // Special service identifiers
    localparam logic [13:0] SID_BCAST = 14'h3FFF;
    localparam logic [13:0] SID_ZERO  = 14'h0000;

    // Full width of the effective time count before M is taken off
    localparam logic [31:0] TIME_MASK = 32'h03FF_FFFF;

    // Byte positions of the message body header
    localparam logic [7:0] P_CHAN  = 8'h00;
    localparam logic [7:0] P_UCD   = 8'h01;
    localparam logic [7:0] P_NELEM = 8'h02;
    localparam logic [7:0] P_RSVD  = 8'h03;
    localparam logic [7:0] P_ALLOC = 8'h04;
    localparam logic [7:0] P_ACK   = 8'h08;
    localparam logic [7:0] P_RBS   = 8'h0C;
    localparam logic [7:0] P_RBE   = 8'h0D;
    localparam logic [7:0] P_DBS   = 8'h0E;
    localparam logic [7:0] P_DBE   = 8'h0F;
    localparam logic [7:0] HDR_BYTES = 8'h10;

    // Sender state
    typedef enum logic [1:0] {ST_IDLE, ST_SEND} umc_state_t;

    // Whole state of the codec
    typedef struct packed {
        logic [7:0]                  chan_id;
        logic [7:0]                  ucd_cnt;
        logic [31:0]                 alloc;
        logic [31:0]                 ack;
        logic [3:0]                  rbs;
        logic [3:0]                  rbe;
        logic [3:0]                  dbs;
        logic [3:0]                  dbe;
        logic [4:0]                  mbits;
        logic [13:0]                 map_len;
        logic [IE_DEPTH-1:0][31:0]   ie;
        logic [CNT_W-1:0]            nwords;
        logic [7:0]                  nelem;
        logic [13:0]                 ext_left;
        logic                        err;
        umc_state_t                  st;
        logic [7:0]                  idx;
        logic                        out_valid;
        logic [7:0]                  out_data;
        logic                        out_last;
        logic [31:0]                 prdata;
        logic                        pslverr;
    } umc_st_t;

endpackage : umc_pkg

// file: umc_map_codec_sva.sv
// Port-level assertions for the allocation map codec
`timescale 1ns/100ps
module umc_map_codec_sva
    import umc_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Body stream
    input wire logic        map_valid,
    input wire logic        map_ready,
    input wire logic [7:0]  map_data,
    input wire logic        map_last,
    input wire logic        busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Index of the body byte on offer
    logic [7:0] idx;
    // Restarts whenever no body is in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx <= 8'h00;
        end else if (!busy) begin
            idx <= 8'h00;
        end else if (map_valid && map_ready) begin
            idx <= idx + 8'h01;
        end
    end
    property p_hold; map_valid && !map_ready |=> map_valid && $stable(map_data)
        && $stable(map_last); endproperty
    a_hold: assert property (p_hold) else $error("stalled byte changed");
    property p_rsvd; map_valid && idx == 8'h03 |-> map_data == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("alignment byte not zero");
    property p_rbo; map_valid && idx inside {8'h0C, 8'h0D} |-> map_data[7:4] == 4'h0;
    endproperty
    a_rbo: assert property (p_rbo) else $error("ranging backoff upper bits");
    property p_dbo; map_valid && idx inside {8'h0E, 8'h0F} |-> map_data[7:4] == 4'h0;
    endproperty
    a_dbo: assert property (p_dbo) else $error("data backoff upper bits");
    property p_last; map_valid && map_last |-> idx >= 8'h0F && idx[1:0] == 2'b11; endproperty
    a_last: assert property (p_last) else $error("body not whole words");
    property p_end; map_valid && map_ready && map_last |=> !map_valid && !busy; endproperty
    a_end: assert property (p_end) else $error("stream did not stop");
    property p_vbusy; map_valid |-> busy; endproperty
    a_vbusy: assert property (p_vbusy) else $error("valid while idle");
    property p_start; $rose(busy) |-> map_valid && idx == 8'h00; endproperty
    a_start: assert property (p_start) else $error("send start late");
    property p_bord; psel && penable && !pwrite && paddr == A_BACKOFF
        |-> (prdata & 32'hF0F0_F0F0) == 32'h0000_0000; endproperty
    a_bord: assert property (p_bord) else $error("backoff read upper bits");
    property p_unmap; psel && penable && paddr > A_ACK_EFF |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
endmodule : umc_map_codec_sva

bind umc_map_codec umc_map_codec_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .map_valid(map_valid), .map_ready(map_ready),
    .map_data(map_data), .map_last(map_last), .busy(busy));

// file: umc_map_sink.sv
// Modem-side model that takes map bodies and counts data grants
`timescale 1ns/100ps
module umc_map_sink
    import umc_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Body stream
    input  wire logic       map_valid,
    output logic            map_ready,
    input  wire logic [7:0] map_data,
    input  wire logic       map_last,
    // Pacing and result
    input  wire logic       slow,
    output logic [7:0]      grants
);
    logic [7:0]  got_q [$]; // Every accepted byte, in order
    logic [23:0] part;      // Earlier bytes of the current word
    logic [7:0]  idx;       // Byte index within the body
    logic [31:0] word;      // Word completed by this byte
    logic [13:0] prev_ofs;  // Offset of the element before
    logic [13:0] glen;      // Length of the latest grant interval
    logic        was_grant; // Element before was a data grant
    logic        is_grant;  // Completed word is a data grant
    assign word = {part, map_data};
    assign is_grant = (word[17:14] == IUC_SHORT) || (word[17:14] == IUC_LONG);
    // Accept bytes; stalls every other cycle when slow
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            map_ready <= 1'b0;
            grants    <= 8'h00;
            idx       <= 8'h00;
            part      <= 24'h00_0000;
            prev_ofs  <= 14'h0000;
            glen      <= 14'h0000;
            was_grant <= 1'b0;
        end else begin
            map_ready <= slow ? !map_ready : 1'b1;
            if (map_valid && map_ready) begin
                got_q.push_back(map_data);
                part <= {part[15:0], map_data};
                idx  <= map_last ? 8'h00 : idx + 8'h01;
                if (idx >= 8'h10 && idx[1:0] == 2'b11) begin
                    // grant length is the next offset minus its own
                    if (was_grant) begin
                        glen <= word[13:0] - prev_ofs;
                    end
                    prev_ofs  <= word[13:0];
                    was_grant <= is_grant;
                    // only grants count, reserved codes skipped
                    if (is_grant) begin
                        grants <= grants + 8'h01;
                    end
                end
            end
        end
    end
endmodule : umc_map_sink

// file: umc_map_codec_tb.sv
// Self-checking bench for the allocation map codec
`timescale 1ns/100ps
module umc_map_codec_tb
    import umc_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;   // Clock, reset, pacing
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, map_valid, map_ready, map_last, busy, er;
    logic [7:0]  map_data, grants;
    logic [7:0]  exp_q [$];   // Expected stream
    logic [31:0] words [$];   // Stored words, expected
    int          mismatches = 0, compares = 0;
    always #12.5 pclk = ~pclk;
    umc_map_codec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .map_valid(map_valid), .map_ready(map_ready),
        .map_data(map_data), .map_last(map_last), .busy(busy));
    umc_map_sink u_sink (.pclk(pclk), .presetn(presetn), .map_valid(map_valid),
        .map_ready(map_ready), .map_data(map_data), .map_last(map_last), .slow(slow),
        .grants(grants));
    // Verdict and end of run
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            complete_run();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        xfer(1'b1, a, d, rd, er);
        chk("write error", {31'h0, e}, {31'h0, er});
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, rd, er);
        chk("read error", 32'h0000_0000, {31'h0, er});
        chk("read data", exp, rd);
    endtask : rdc
    // Append an element; data acks carry the map length
    task automatic push(input logic [31:0] w, input logic ok);
        wr(A_IE_PUSH, w, 1'b0);
        if (ok) begin
            words.push_back(w[17:14] == IUC_DACK ? {w[31:14], 14'h0123} : w);
        end
    endtask : push
    // Expected body: header then stored words, big endian
    task automatic body(input logic [7:0] ne);
        exp_q = {exp_q, 8'h5A, 8'h3C, ne, 8'h00, 8'hDE, 8'hAD, 8'hBE, 8'hEF};
        exp_q = {exp_q, 8'h01, 8'h23, 8'h45, 8'h67, 8'h00, 8'h01, 8'h03, 8'h07};
        foreach (words[i]) begin
            exp_q = {exp_q, words[i][31:24], words[i][23:16], words[i][15:8], words[i][7:0]};
        end
        words.delete();
    endtask : body
    // Bounded wait for the sender to go idle
    task automatic wait_idle;
        int n;
        // Let the send command's edge pass before looking at busy
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_idle
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(A_STATUS, 32'h0000_0000);
        rdc(A_IE_PUSH, 32'h0000_0000);
        wr(A_CHAN, 32'h0000_005A, 1'b0);
        wr(A_UCD, 32'h0000_003C, 1'b0);
        wr(A_ALLOC, 32'hDEAD_BEEF, 1'b0);
        wr(A_ACK, 32'h0123_4567, 1'b0);
        wr(A_BACKOFF, 32'hF7F3_F1F0, 1'b0);
        rdc(A_BACKOFF, 32'h0703_0100);
        wr(A_MAPLEN, 32'h0000_0123, 1'b0);
        wr(A_MBITS, 32'h0000_0004, 1'b0);
        rdc(A_ALLOC_EFF, 32'h002D_BEEF);
        rdc(A_ACK_EFF, 32'h0023_4567);
        wr(A_MBITS, 32'h0000_001B, 1'b0);
        rdc(A_ALLOC_EFF, 32'h0000_0000);
        push({14'h0123, IUC_REQ, 14'h0000}, 1'b1);
        push({14'h3FF0, IUC_REQD, 14'h0004}, 1'b1);
        push({SID_BCAST, IUC_INIT, 14'h0008}, 1'b1);
        push({14'h0001, IUC_INIT, 14'h0009}, 1'b0);
        push({14'h0055, IUC_STAT, 14'h000C}, 1'b1);
        push({SID_ZERO, IUC_STAT, 14'h000D}, 1'b0);
        push({14'h0077, IUC_SHORT, 14'h0014}, 1'b1);
        push({14'h0077, IUC_LONG, 14'h0018}, 1'b1);
        push({14'h0001, IUC_NULL, 14'h0028}, 1'b0);
        push({SID_ZERO, IUC_NULL, 14'h0028}, 1'b1);
        push({14'h0088, IUC_DACK, 14'h0000}, 1'b1);
        push({14'h00AA, 4'h9, 14'h002C}, 1'b1);
        rdc(A_STATUS, 32'h0000_0002);
        wr(A_STATUS, 32'h0000_0002, 1'b0);
        push({14'h0005, IUC_EXP, 14'h0001}, 1'b1);
        wr(A_CTRL, 32'h0000_0001, 1'b0);
        rdc(A_STATUS, 32'h0000_000A);
        push(32'h1234_5678, 1'b1);
        wr(A_STATUS, 32'h0000_0002, 1'b0);
        rdc(A_IE_PUSH, 32'h0000_0A0B);
        slow <= 1'b1;
        body(8'h0A);
        wr(A_CTRL, 32'h0000_0001, 1'b0);
        rdc(A_STATUS, 32'h0000_0001);
        wr(A_IE_PUSH, 32'h0000_0000, 1'b1);
        wait_idle();
        chk("grants", 32'h0000_0002, {24'h0, grants});
        chk("grant length", 32'h0000_0010, {18'h0, u_sink.glen});
        slow <= 1'b0;
        wr(A_CTRL, 32'h0000_0003, 1'b0);
        rdc(A_STATUS, 32'h0000_0000);
        rdc(A_IE_PUSH, 32'h0000_0000);
        repeat (32) wr(A_IE_PUSH, 32'h0000_0000, 1'b0);
        rdc(A_STATUS, 32'h0000_0004);
        wr(A_IE_PUSH, 32'h0000_0000, 1'b1);
        wr(A_CTRL, 32'h0000_0002, 1'b0);
        body(8'h00);
        wr(A_CTRL, 32'h0000_0001, 1'b0);
        wait_idle();
        xfer(1'b0, 8'h30, 32'h0000_0000, rd, er);
        chk("unmapped error", 32'h0000_0001, {31'h0, er});
        chk("stream length", exp_q.size(), u_sink.got_q.size());
        chk("sink index", 32'h0000_0000, {24'h0, u_sink.idx});
        foreach (exp_q[i]) begin
            chk("stream byte", {24'h0, exp_q[i]}, {24'h0, u_sink.got_q[i]});
        end
        complete_run();
    end
endmodule : umc_map_codec_tb
